// ==== rtl/arar_map.svh ====
// register offsets, field positions and reset values of the range/alarm bank
`ifndef ARAR_MAP_SVH
`define ARAR_MAP_SVH

// byte addresses
`define ARAR_RANGE_B0      8'h14
`define ARAR_RANGE_B1      8'h15
`define ARAR_RANGE_B2      8'h16
`define ARAR_RANGE_B3      8'h17
`define ARAR_ALARM_B0      8'h20
`define ARAR_ALARM_B1      8'h21
`define ARAR_ALARM_B2      8'h22
`define ARAR_ALARM_B3      8'h23
`define ARAR_IRQ_STAT      8'h30
`define ARAR_IRQ_MASK      8'h31

// range register fields
`define ARAR_REFOFF_BIT    6
`define ARAR_RANGE_MSB     3
`define ARAR_RANGE_RST     4'h0
`define ARAR_REFOFF_RST    1'b0

// alarm register fields
`define ARAR_ACT_SUP_LO    15
`define ARAR_ACT_SUP_HI    14
`define ARAR_ACT_IN_LO     11
`define ARAR_ACT_IN_HI     10
`define ARAR_LAT_SUP_LO    7
`define ARAR_LAT_SUP_HI    6
`define ARAR_LAT_IN_LO     5
`define ARAR_LAT_IN_HI     4
`define ARAR_ANY_BIT       0

// interrupt status/mask bits
`define ARAR_IRQ_TRIP      0
`define ARAR_IRQ_RANGE     1
`define ARAR_IRQ_RST       2'h0

`endif

// ==== rtl/arar_pkg.sv ====
// types of the range/alarm register bank
package arar_pkg;

    // raw comparator results of one conversion
    typedef struct packed {
        logic supply_low;
        logic supply_high;
        logic input_low;
        logic input_high;
    } arar_cmp_type;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } arar_req_type;

    // decoded span of the range field
    typedef struct packed {
        logic       bipolar;
        logic [3:0] span_x1000; // span in reference multiples, thousandths
        logic       legal;
    } arar_dummy_type;

    typedef enum logic [2:0] {
        ARAR_SPAN_NONE = 3'h0,
        ARAR_SPAN_3    = 3'h1,
        ARAR_SPAN_2P5  = 3'h2,
        ARAR_SPAN_1P5  = 3'h3,
        ARAR_SPAN_1P25 = 3'h4,
        ARAR_SPAN_P625 = 3'h5
    } arar_span_type;

    typedef struct packed {
        logic          bipolar;
        arar_span_type span;
    } arar_range_type;

    // whole state of the bank
    typedef struct packed {
        logic [3:0]   range_sel;
        logic         internal_ref_off;
        arar_cmp_type active;
        arar_cmp_type latched;
        logic [1:0]   irq_stat;
        logic [1:0]   irq_mask;
        logic [7:0]   rdata;
        logic         irq;
        logic         ref_en;
        arar_range_type range;
    } arar_state_type;

endpackage

// ==== rtl/arar_regs.sv ====
// range-selection and alarm-flag register bank with byte access
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "arar_map.svh"

// ****************************************************************
// contract
// ****************************************************************
// Contract
// - range register reads zero except bit 6 and bits 3-0
// - bit 6 high disables internal reference; resets to 0
// - codes 0000b-0100b select bipolar spans 3, 2.5, 1.5, 1.25, 0.625
// - codes 1000b-1011b select unipolar spans; field resets to zero
// - range register upper bytes sit at 15h, 16h, 17h
// - alarm register read-only, flags reset 0, upper half reads zero
// - bit 15 active supply low, bit 14 active supply high
// - bit 11 active input low, bit 10 active input high
// - bit 7 latched supply low, bit 6 latched supply high
// - bit 5 latched input low, bit 4 latched input high
// - bit 0 is OR of latched flags; other gaps read zero
// - alarm register bytes sit at 20h, 21h, 22h, 23h
// - range low byte at 14h; reset clears range and reference bit
module arar_regs #(
    // register port address width
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    // register port
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [7:0]            rdata,
    // comparator results
    input  wire logic                  conv_done,
    input  wire arar_pkg::arar_cmp_type cmp,
    // to the converter
    output logic                       ref_en,
    output arar_pkg::arar_range_type   range,
    // interrupt
    output logic                       irq
);

    arar_pkg::arar_state_type s_q;
    arar_pkg::arar_state_type s_d;

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("register port address must be eight bits wide");
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic arar_pkg::arar_range_type decode_range(
        input logic [3:0] code);
        arar_pkg::arar_range_type r;
        r.bipolar = ~code[3];
        case (code)
            4'h0, 4'h8: r.span = arar_pkg::ARAR_SPAN_3;
            4'h1, 4'h9: r.span = arar_pkg::ARAR_SPAN_2P5;
            4'h2, 4'hA: r.span = arar_pkg::ARAR_SPAN_1P5;
            4'h3, 4'hB: r.span = arar_pkg::ARAR_SPAN_1P25;
            4'h4:       r.span = arar_pkg::ARAR_SPAN_P625;
            default:    r.span = arar_pkg::ARAR_SPAN_NONE;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] alarm_low(
        input arar_pkg::arar_cmp_type act,
        input arar_pkg::arar_cmp_type lat);
        logic [15:0] v;
        v = 16'h0000;
        v[`ARAR_ACT_SUP_LO] = act.supply_low;
        v[`ARAR_ACT_SUP_HI] = act.supply_high;
        v[`ARAR_ACT_IN_LO]  = act.input_low;
        v[`ARAR_ACT_IN_HI]  = act.input_high;
        v[`ARAR_LAT_SUP_LO] = lat.supply_low;
        v[`ARAR_LAT_SUP_HI] = lat.supply_high;
        v[`ARAR_LAT_IN_LO]  = lat.input_low;
        v[`ARAR_LAT_IN_HI]  = lat.input_high;
        v[`ARAR_ANY_BIT]    = |lat;
        return v;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [15:0]            alarm_word;
        logic [7:0]             range_byte;
        logic                   alarm_rd;
        arar_pkg::arar_cmp_type trip;
        logic                   range_wr;
        alarm_word = alarm_low(s_q.active, s_q.latched);
        range_byte = 8'h00;
        range_byte[`ARAR_REFOFF_BIT] = s_q.internal_ref_off;
        range_byte[`ARAR_RANGE_MSB:0] = s_q.range_sel;
        alarm_rd = rd && (addr == `ARAR_ALARM_B0 ||
                          addr == `ARAR_ALARM_B1);
        trip = conv_done ? cmp : '0;
        range_wr = wr && addr == `ARAR_RANGE_B0;
        s_d = s_q;
        // read data, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `ARAR_RANGE_B0: s_d.rdata = range_byte;
                `ARAR_RANGE_B1: s_d.rdata = 8'h00;
                `ARAR_RANGE_B2: s_d.rdata = 8'h00;
                `ARAR_RANGE_B3: s_d.rdata = 8'h00;
                `ARAR_ALARM_B0: s_d.rdata = alarm_word[7:0];
                `ARAR_ALARM_B1: s_d.rdata = alarm_word[15:8];
                `ARAR_ALARM_B2: s_d.rdata = 8'h00;
                `ARAR_ALARM_B3: s_d.rdata = 8'h00;
                `ARAR_IRQ_STAT: s_d.rdata = {6'h00, s_q.irq_stat};
                `ARAR_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
                default:        s_d.rdata = 8'h00;
            endcase
        end
        // writes; alarm bytes ignore writes
        if (range_wr) begin
            s_d.internal_ref_off = wdata[`ARAR_REFOFF_BIT];
            s_d.range_sel = wdata[`ARAR_RANGE_MSB:0];
        end
        if (wr && addr == `ARAR_IRQ_MASK) begin
            s_d.irq_mask = wdata[1:0];
        end
        // flags: active follows each conversion, latched sticky until read
        if (conv_done) begin
            s_d.active = cmp;
        end
        if (alarm_rd) begin
            s_d.latched = '0;
        end
        s_d.latched = s_d.latched | trip;
        // interrupt status: read clears, new event wins
        if (rd && addr == `ARAR_IRQ_STAT) begin
            s_d.irq_stat = `ARAR_IRQ_RST;
        end
        if (|trip) begin
            s_d.irq_stat[`ARAR_IRQ_TRIP] = 1'b1;
        end
        if (range_wr) begin
            s_d.irq_stat[`ARAR_IRQ_RANGE] = 1'b1;
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        s_d.ref_en = ~s_d.internal_ref_off;
        s_d.range = decode_range(s_d.range_sel);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.range_sel <= `ARAR_RANGE_RST;
            s_q.internal_ref_off <= `ARAR_REFOFF_RST;
            s_q.ref_en <= 1'b1;
            s_q.range.bipolar <= 1'b1;
            s_q.range.span <= arar_pkg::ARAR_SPAN_3;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rdata  = s_q.rdata;
    assign ref_en = s_q.ref_en;
    assign range  = s_q.range;
    assign irq    = s_q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    range_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == `ARAR_RANGE_B0 |=>
        (rdata & 8'hB0) == 8'h00 &&
        rdata[3:0] == $past(s_q.range_sel))
        else $error("range byte reserved bits not zero");

    ref_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr == `ARAR_RANGE_B0 |=>
        ##1 ref_en == !$past(wdata[6], 2))
        else $error("reference enable does not follow write");

    bip_span_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h4 |->
        range.bipolar && range.span == arar_pkg::ARAR_SPAN_P625)
        else $error("bipolar span decode wrong");

    uni_span_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr == `ARAR_RANGE_B0 && wdata[3:0] == 4'h8
        ##1 clk_en |=> !range.bipolar &&
        range.span == arar_pkg::ARAR_SPAN_3)
        else $error("unipolar span decode wrong");

    upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && (addr == `ARAR_RANGE_B2 || addr == `ARAR_ALARM_B3)
        |=> rdata == 8'h00)
        else $error("upper byte not zero");

    alarm_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr == `ARAR_ALARM_B1 && !conv_done && !rd
        |=> s_q.active == $past(s_q.active))
        else $error("alarm register changed by write");

    act_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_done ##1 clk_en && rd && addr == `ARAR_ALARM_B1
        |=> rdata[7] == $past(cmp.supply_low, 2) &&
        rdata[2] == $past(cmp.input_high, 2))
        else $error("active flag mismatch");

    any_or_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == `ARAR_ALARM_B0 |=>
        rdata[0] == |rdata[7:4] && rdata[3:1] == 3'h0)
        else $error("summary flag not OR of latched flags");

    trip_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_done && cmp.input_low ##1
        (clk_en && !(rd && addr inside {`ARAR_ALARM_B0, `ARAR_ALARM_B1}))
        [*2] |-> s_q.latched.input_low)
        else $error("latched flag lost before read");

    // ****************************************************************
    // checks: range register
    // ****************************************************************
    range_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr == `ARAR_RANGE_B0 |=>
        s_q.range_sel == $past(wdata[`ARAR_RANGE_MSB:0]) &&
        s_q.internal_ref_off == $past(wdata[`ARAR_REFOFF_BIT]))
        else $error("range write not stored");

    range_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr inside {`ARAR_RANGE_B1, `ARAR_RANGE_B2,
        `ARAR_RANGE_B3} |=> s_q.range_sel == $past(s_q.range_sel) &&
        s_q.internal_ref_off == $past(s_q.internal_ref_off))
        else $error("upper range byte write changed state");

    range_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr inside {`ARAR_RANGE_B1, `ARAR_RANGE_B2,
        `ARAR_RANGE_B3} |=> rdata == 8'h00)
        else $error("upper range byte not zero");

    ref_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ref_en == !s_q.internal_ref_off)
        else $error("reference enable not inverse of disable bit");

    bip_3_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h0 |->
        range.bipolar && range.span == arar_pkg::ARAR_SPAN_3)
        else $error("code 0 decode wrong");

    bip_2p5_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h1 |->
        range.bipolar && range.span == arar_pkg::ARAR_SPAN_2P5)
        else $error("code 1 decode wrong");

    bip_1p5_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h2 |->
        range.bipolar && range.span == arar_pkg::ARAR_SPAN_1P5)
        else $error("code 2 decode wrong");

    bip_1p25_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h3 |->
        range.bipolar && range.span == arar_pkg::ARAR_SPAN_1P25)
        else $error("code 3 decode wrong");

    uni_2p5_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'h9 |->
        !range.bipolar && range.span == arar_pkg::ARAR_SPAN_2P5)
        else $error("code 9 decode wrong");

    uni_1p5_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'hA |->
        !range.bipolar && range.span == arar_pkg::ARAR_SPAN_1P5)
        else $error("code A decode wrong");

    uni_1p25_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel == 4'hB |->
        !range.bipolar && range.span == arar_pkg::ARAR_SPAN_1P25)
        else $error("code B decode wrong");

    span_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.range_sel inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE,
        4'hF} |-> range.span == arar_pkg::ARAR_SPAN_NONE)
        else $error("unused code decodes to a span");

    // ****************************************************************
    // checks: alarm register
    // ****************************************************************
    alarm_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr inside {`ARAR_ALARM_B2, `ARAR_ALARM_B3}
        |=> rdata == 8'h00)
        else $error("upper alarm byte not zero");

    lat_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == `ARAR_ALARM_B0 |=>
        rdata[7:4] == $past(s_q.latched))
        else $error("latched flags read wrong");

    act_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == `ARAR_ALARM_B1 |=>
        {rdata[7:6], rdata[3:2]} == $past(s_q.active) &&
        rdata[5:4] == 2'h0 && rdata[1:0] == 2'h0)
        else $error("active flags read wrong");

    act_take_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_done |=> s_q.active == $past(cmp))
        else $error("active flags not taken from conversion");

    act_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !conv_done |=> s_q.active == $past(s_q.active))
        else $error("active flags changed without conversion");

    lat_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_done |=>
        (s_q.latched & $past(cmp)) == $past(cmp))
        else $error("latched flag not set by conversion");

    lat_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr inside {`ARAR_ALARM_B0, `ARAR_ALARM_B1} &&
        !conv_done |=> s_q.latched == '0)
        else $error("latched flags not cleared by read");

    // ****************************************************************
    // checks: interrupt and read port
    // ****************************************************************
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(s_q.irq_stat & s_q.irq_mask))
        else $error("interrupt level wrong");

    stat_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == `ARAR_IRQ_STAT |=>
        rdata == {6'h00, $past(s_q.irq_stat)})
        else $error("interrupt status read wrong");

    stat_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && !wr && addr == `ARAR_IRQ_STAT && !conv_done |=>
        s_q.irq_stat == `ARAR_IRQ_RST)
        else $error("interrupt status not cleared by read");

    rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    state_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> s_q == $past(s_q))
        else $error("state changed while clock enable low");

endmodule

// ==== bench/arar_host.sv ====
// host model that drives the byte register port
`timescale 1ns/1ns

// ****************************************************************
// host
// ****************************************************************
module arar_host (
    // clock
    input  wire logic       clk,
    // register port
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one-cycle write; idle lines show inverted garbage afterwards
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    // one-cycle read; data taken in the cycle after the strobe
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = rdata;
    endtask
endmodule

// ==== bench/adc_range_alarm_regs_test.sv ====
// self-checking bench of the range/alarm register bank
`timescale 1ns/1ns

// ****************************************************************
// bench
// ****************************************************************
module adc_range_alarm_regs_test;
    logic                     clk = 1'b0;
    logic                     rst_n;
    logic                     clk_en;
    logic [7:0]               addr;
    logic [7:0]               wdata;
    logic                     wr;
    logic                     rd;
    logic [7:0]               rdata;
    logic                     conv_done;
    arar_pkg::arar_cmp_type   cmp;
    logic                     ref_en;
    arar_pkg::arar_range_type range;
    logic                     irq;
    int                       n_fail;
    int                       n_checks;
    logic [7:0]               v;

    always #5 clk = ~clk;

    arar_regs u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .conv_done(conv_done), .cmp(cmp), .ref_en(ref_en),
        .range(range), .irq(irq));
    arar_host u_host (.clk(clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [2:0] exp_span(input logic [3:0] c);
        if (!c[3] && c[2:0] <= 3'h4) return c[2:0] + 3'h1;
        if (c[3] && !c[2]) return {1'b0, c[1:0]} + 3'h1;
        return 3'h0;
    endfunction

    // one conversion result on the comparator input
    task automatic trip(input logic [3:0] c);
        @(posedge clk);
        conv_done <= 1'b1;
        cmp       <= c;
        @(posedge clk);
        conv_done <= 1'b0;
        cmp       <= ~c;
    endtask

    task automatic test_reset;
        check({7'h00, ref_en}, 8'h01);
        check({4'h0, range}, 8'h09);
        check({7'h00, irq}, 8'h00);
        for (int a = 0; a < 4; a++) begin
            u_host.read_byte(8'h14 + 8'(a), v);
            check(v, 8'h00);
            u_host.read_byte(8'h20 + 8'(a), v);
            check(v, 8'h00);
        end
    endtask

    task automatic test_range;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            u_host.write_byte(8'h14, {1'b1, c[0], 2'b11, c});
            u_host.read_byte(8'h14, v);
            check(v, {1'b0, c[0], 2'b00, c});
            check({7'h00, ref_en}, {7'h00, ~c[0]});
            check({5'h00, range.span}, {5'h00, exp_span(c)});
            if (exp_span(c) != 3'h0)
                check({7'h00, range.bipolar}, {7'h00, ~c[3]});
        end
        for (int a = 1; a < 4; a++) begin
            u_host.write_byte(8'h14 + 8'(a), 8'hFF);
            u_host.write_byte(8'h1F + 8'(a), 8'hFF);
            u_host.read_byte(8'h14 + 8'(a), v);
            check(v, 8'h00);
            u_host.read_byte(8'h1F + 8'(a), v);
            check(v, 8'h00);
        end
        u_host.read_byte(8'h14, v);
        check(v, 8'h4F);
    endtask

    task automatic test_alarm;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            trip(c);
            u_host.read_byte(8'h20, v);
            check(v, {c, 3'b000, |c});
            u_host.read_byte(8'h21, v);
            check(v, {c[3:2], 2'b00, c[1:0], 2'b00});
            u_host.read_byte(8'h20, v);
            check(v, 8'h00);
        end
        trip(4'h0);
        u_host.read_byte(8'h21, v);
        check(v, 8'h00);
        @(posedge clk);
        clk_en <= 1'b0;
        trip(4'hF);
        clk_en <= 1'b1;
        u_host.read_byte(8'h20, v);
        check(v, 8'h00);
        u_host.read_byte(8'h21, v);
        check(v, 8'h00);
    endtask

    task automatic test_irq;
        u_host.read_byte(8'h30, v);
        u_host.write_byte(8'h31, 8'h01);
        trip(4'h2);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({7'h00, irq}, 8'h01);
        u_host.read_byte(8'h30, v);
        check(v, 8'h01);
        @(negedge clk);
        check({7'h00, irq}, 8'h00);
        u_host.write_byte(8'h14, 8'h00);
        repeat (3) @(negedge clk);
        check({7'h00, irq}, 8'h00);
        u_host.read_byte(8'h30, v);
        check(v, 8'h02);
        u_host.read_byte(8'h31, v);
        check(v, 8'h01);
        u_host.read_byte(8'h40, v);
        check(v, 8'h00);
        @(negedge clk);
        check(rdata, 8'h00);
    endtask

    initial begin
        n_fail    = 0;
        n_checks  = 0;
        rst_n     = 1'b0;
        clk_en    = 1'b1;
        conv_done = 1'b0;
        cmp       = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_range;
        test_alarm;
        test_irq;
        finish_test;
    end

    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
endmodule
